//--- design/svw_pkg.sv
// Package of the supervisor delay and window select block.
// Holds timing constants, register map, field layouts, states and carriers.
// Assumes a single 200 MHz clock and a 1 us internal timebase tick.
package svw_pkg;

    // Timebase: one tick per microsecond
    localparam int unsigned CLK_MHZ = 200;
    localparam int unsigned TICK_US = 1;
    localparam int unsigned TICK_CYC = CLK_MHZ * TICK_US;
    localparam int unsigned TICK_CNT_W = 16;

    // Interval counters count ticks; wide enough for the longest capacitor window
    localparam int CNT_W = 27;
    typedef logic [CNT_W-1:0] svw_cnt_t;

    // Pin identification timing, in us
    localparam svw_cnt_t DET_PD_US = 27'd190;
    localparam svw_cnt_t DET_TOTAL_US = 27'd381;

    // Reset release delays, in us
    localparam svw_cnt_t RST_NC_US = 27'd200000;
    localparam svw_cnt_t RST_PU_US = 27'd10000;
    localparam svw_cnt_t RST_CAP_MIN_US = 27'd700;
    localparam svw_cnt_t RST_CAP_MAX_US = 27'd3200000;

    // Factory watchdog windows and capacitor upper bound span, in us
    localparam svw_cnt_t WDL_NC_00_US = 27'd22500;
    localparam svw_cnt_t WDU_NC_00_US = 27'd55000;
    localparam svw_cnt_t WDL_NC_01_US = 27'd1850;
    localparam svw_cnt_t WDU_NC_01_US = 27'd27500;
    localparam svw_cnt_t WDL_NC_11_US = 27'd800000;
    localparam svw_cnt_t WDU_NC_11_US = 27'd1600000;
    localparam svw_cnt_t WDL_PU_00_US = 27'd9000;
    localparam svw_cnt_t WDU_PU_00_US = 27'd109000;
    localparam svw_cnt_t WDL_PU_01_US = 27'd9000;
    localparam svw_cnt_t WDU_PU_01_US = 27'd195000;
    localparam svw_cnt_t WDL_PU_11_US = 27'd1850;
    localparam svw_cnt_t WDU_PU_11_US = 27'd11000;
    localparam svw_cnt_t WDU_CAP_MIN_US = 27'd62740;
    localparam svw_cnt_t WDU_CAP_MAX_US = 27'd77455000;

    // Ratio select codes {sel_a, sel_b}
    localparam logic [1:0] SEL_OFF = 2'h2;

    // Register byte offsets
    localparam logic [7:0] REG_STATUS = 8'h00;
    localparam logic [7:0] REG_MASK = 8'h04;
    localparam logic [7:0] REG_CAP_RST = 8'h08;
    localparam logic [7:0] REG_CAP_WD = 8'h0C;
    localparam logic [7:0] REG_INFO = 8'h10;

    // Status and mask bit positions
    localparam int EV_WD_FAULT = 0;
    localparam int EV_RST_ASSERT = 1;
    localparam int EV_DET_DONE = 2;
    localparam int EV_W = 3;

    // Info register field positions
    localparam int INFO_RST_OPT = 0;
    localparam int INFO_WD_OPT = 2;
    localparam int INFO_SEL = 4;
    localparam int INFO_STATE = 6;
    localparam int INFO_RST_N = 8;
    localparam int INFO_WDO = 9;
    localparam int INFO_WD_OFF = 10;

    // Values after reset
    localparam logic [EV_W-1:0] STATUS_RST = 3'h0;
    localparam logic [EV_W-1:0] MASK_RST = 3'h0;
    localparam svw_cnt_t CAP_RST_RST = 27'd700;
    localparam svw_cnt_t CAP_WD_RST = 27'd62740;

    // Detected pin option
    typedef enum logic [1:0] {
        OPT_NC = 2'b00,
        OPT_PU = 2'b01,
        OPT_CAP = 2'b10
    } svw_opt_t;

    // Supervisor sequence
    typedef enum logic [1:0] {
        SV_HOLD = 2'b00,
        SV_DETECT = 2'b01,
        SV_DELAY = 2'b10,
        SV_RUN = 2'b11
    } svw_state_t;

    // Pin detector sequence
    typedef enum logic [1:0] {
        DT_IDLE = 2'b00,
        DT_PULL = 2'b01,
        DT_FLOAT = 2'b10
    } svw_det_state_t;

    // APB request from the master
    typedef struct packed {
        logic psel;
        logic penable;
        logic pwrite;
        logic [7:0] paddr;
        logic [31:0] pwdata;
    } svw_apb_req_t;

    // APB answer to the master
    typedef struct packed {
        logic pready;
        logic pslverr;
        logic [31:0] prdata;
    } svw_apb_rsp_t;

    // Latched configuration
    typedef struct packed {
        svw_opt_t rst_opt;
        svw_opt_t wd_opt;
        logic [1:0] sel;
    } svw_cfg_t;

    // Watchdog window bounds in ticks
    typedef struct packed {
        svw_cnt_t lower;
        svw_cnt_t upper;
    } svw_win_t;

endpackage : svw_pkg

//--- design/svw_interval.sv
// Saturating tick counter for delay and window timing.
// Assumes tick is a one-cycle enable from the timebase divider.
`timescale 1ns/10ps
module svw_interval (
    // Clock and reset
    input wire logic mclk,
    input wire logic srst,
    // Control
    input wire logic clr,
    input wire logic tick,
    // Elapsed ticks
    output svw_pkg::svw_cnt_t cnt_q
);
    import svw_pkg::*;

    // Count ticks from clear, stop at full scale
    always_ff @(posedge mclk) begin
        if (srst || clr) begin
            cnt_q <= '0;
        end else if (tick && (cnt_q != '1)) begin
            cnt_q <= cnt_q + 1'b1;
        end
    end

endmodule : svw_interval

//--- design/svw_pin_detect.sv
// Identification of what hangs on a configuration pin.
// Assumes the pin wire is resolved outside: a pull-up reads high even while
// the pulldown is on, an open pin floats high once released, a capacitor stays low.
`timescale 1ns/10ps
module svw_pin_detect (
    // Clock and reset
    input wire logic mclk,
    input wire logic srst,
    // Control
    input wire logic tick,
    input wire logic start,
    // Pin
    input wire logic pin_i,
    output logic pd_oe,
    // Result
    output logic done_q,
    output svw_pkg::svw_opt_t opt_q
);
    import svw_pkg::*;

    svw_det_state_t st_q;
    svw_cnt_t t_q;
    logic high_seen_q;

    // Pulldown phase then released phase, 381 ticks in all
    always_ff @(posedge mclk) begin
        if (srst) begin
            st_q <= DT_IDLE;
            t_q <= '0;
            high_seen_q <= 1'b0;
            done_q <= 1'b0;
            opt_q <= OPT_NC;
        end else begin
            done_q <= 1'b0;
            unique case (st_q)
                DT_IDLE: begin
                    if (start) begin
                        st_q <= DT_PULL;
                        t_q <= '0;
                    end
                end
                DT_PULL: begin
                    if (tick) begin
                        t_q <= t_q + 1'b1;
                        if (t_q == DET_PD_US - 1'b1) begin
                            high_seen_q <= pin_i; // High against the pulldown
                            st_q <= DT_FLOAT;
                        end
                    end
                end
                DT_FLOAT: begin
                    if (tick) begin
                        t_q <= t_q + 1'b1;
                        if (t_q == DET_TOTAL_US - 1'b1) begin
                            // Pull-up, open pin or capacitor
                            opt_q <= high_seen_q ? OPT_PU : (pin_i ? OPT_NC : OPT_CAP);
                            done_q <= 1'b1;
                            st_q <= DT_IDLE;
                        end
                    end
                end
                default: st_q <= DT_IDLE;
            endcase
        end
    end

    // Pulldown drives the pin only in the first phase
    assign pd_oe = (st_q == DT_PULL);

endmodule : svw_pin_detect

//--- design/svw_top.sv
// Supervisor reset delay and window watchdog timing selection, APB slave.
// Assumes inputs synchronous to mclk and an outside wire model that resolves
// each configuration pin from its output enable (drive low when high).
//
// Implementation choices: the APB register port and the placing of the registers.
`timescale 1ns/10ps

// How it works
// - Reset delay comes from capacitor, pull-up or open delay pin
// - Detector pulls the pin down, samples it, finishes within 381 us
// - Pin detection reruns every time reset asserts
// - Factory delay is 200 ms open, 10 ms with pull-up
// - Capacitor delay spans 700 us to 3.2 s
// - Capacitor delay is the programmed REG_CAP_RST count, clamped to those bounds
// - Delay capacitor is discharged by pulldown while a supply fault holds reset
// - After faults clear, charge, then release reset at threshold
// - Open or pulled-up watchdog pin gives factory windows, else capacitor
// - Open watchdog pin windows per select, select 10 disables
// - Pulled-up watchdog pin windows per select, select 10 disables
// - Select a high, b low disables watchdog, fault never asserts
// - Falling-edge kicks; first before upper, later inside window, else fault
// - During reset kicks are ignored and fault output stays released
// - Fault output stays low for the reset release delay
module svw_top #(
    parameter int unsigned TICK_CYC = svw_pkg::TICK_CYC
) (
    // Clock and reset
    input wire logic mclk,
    input wire logic srst,
    // APB slave
    input svw_pkg::svw_apb_req_t apb_req,
    output svw_pkg::svw_apb_rsp_t apb_rsp,
    // Supply or sense out of its valid window
    input wire logic supply_fault,
    // Reset delay configuration pin
    input wire logic reset_delay_config_pin_i,
    output logic reset_delay_config_pin_o,
    output logic reset_delay_config_pin_oe,
    // Watchdog window configuration pin
    input wire logic watchdog_window_config_pin_i,
    output logic watchdog_window_config_pin_o,
    output logic watchdog_window_config_pin_oe,
    // Ratio selects and kick
    input wire logic window_ratio_sel_a,
    input wire logic window_ratio_sel_b,
    input wire logic watchdog_kick_input,
    // Outputs to the host
    output logic reset_out_n,
    output logic watchdog_fault_output_o,
    output logic watchdog_fault_output_oe,
    output logic irq
);
    import svw_pkg::*;

    // Limit a programmed count to its legal span
    function automatic svw_cnt_t clamp_us(svw_cnt_t v, svw_cnt_t lo, svw_cnt_t hi);
        svw_cnt_t r;
        r = v;
        if (v < lo) begin
            r = lo;
        end else if (v > hi) begin
            r = hi;
        end
        return r;
    endfunction : clamp_us

    // Window bounds from pin option, selects and capacitor count
    function automatic svw_win_t win_bounds(svw_opt_t opt, logic [1:0] sel, svw_cnt_t cap_u);
        svw_win_t w;
        svw_cnt_t u;
        w.lower = '0;
        w.upper = '0;
        u = clamp_us(cap_u, WDU_CAP_MIN_US, WDU_CAP_MAX_US);
        if (opt == OPT_NC) begin
            // Open pin table
            unique case (sel)
                2'h0: w = '{lower: WDL_NC_00_US, upper: WDU_NC_00_US};
                2'h1: w = '{lower: WDL_NC_01_US, upper: WDU_NC_01_US};
                2'h3: w = '{lower: WDL_NC_11_US, upper: WDU_NC_11_US};
                2'h2: w = '{lower: '0, upper: '0};
            endcase
        end else if (opt == OPT_PU) begin
            // Pull-up table
            unique case (sel)
                2'h0: w = '{lower: WDL_PU_00_US, upper: WDU_PU_00_US};
                2'h1: w = '{lower: WDL_PU_01_US, upper: WDU_PU_01_US};
                2'h3: w = '{lower: WDL_PU_11_US, upper: WDU_PU_11_US};
                2'h2: w = '{lower: '0, upper: '0};
            endcase
        end else begin
            // Capacitor sets upper, ratio sets lower: 1/8, 3/4, 1/2
            w.upper = u;
            unique case (sel)
                2'h0: w.lower = u >> 3;
                2'h1: w.lower = (u >> 1) + (u >> 2);
                2'h3: w.lower = u >> 1;
                2'h2: w.lower = '0;
            endcase
        end
        return w;
    endfunction : win_bounds

    logic [TICK_CNT_W-1:0] div_q;
    logic tick;
    svw_state_t state_q;
    svw_state_t state_d;
    svw_cfg_t cfg_q;
    logic det_start;
    logic rst_det_done;
    logic rst_det_pd;
    logic wd_det_pd;
    svw_opt_t rst_det_opt;
    svw_opt_t wd_det_opt;
    svw_cnt_t dly_cnt;
    svw_cnt_t win_cnt;
    svw_cnt_t rst_dly;
    svw_win_t win;
    logic wd_off;
    logic fault_q;
    logic first_q;
    logic kick_prev_q;
    logic kick_fall;
    logic wd_active;
    logic fault_start;
    logic fault_end;
    logic [EV_W-1:0] status_q;
    logic [EV_W-1:0] mask_q;
    logic [EV_W-1:0] events;
    svw_cnt_t cap_rst_q;
    svw_cnt_t cap_wd_q;
    logic apb_wr;
    logic apb_setup;
    logic addr_ok;
    logic [31:0] rdata;
    logic [31:0] prdata_q;

    // Timebase divider: one-cycle tick every TICK_CYC clocks
    always_ff @(posedge mclk) begin
        if (srst || tick) begin
            div_q <= '0;
        end else begin
            div_q <= div_q + 1'b1;
        end
    end
    assign tick = (div_q == TICK_CNT_W'(TICK_CYC - 1));

    // Both pins are identified together once faults clear
    assign det_start = (state_q == SV_HOLD) && !supply_fault;

    svw_pin_detect u_rst_det (
        .mclk(mclk),
        .srst(srst),
        .tick(tick),
        .start(det_start),
        .pin_i(reset_delay_config_pin_i),
        .pd_oe(rst_det_pd),
        .done_q(rst_det_done),
        .opt_q(rst_det_opt)
    );

    svw_pin_detect u_wd_det (
        .mclk(mclk),
        .srst(srst),
        .tick(tick),
        .start(det_start),
        .pin_i(watchdog_window_config_pin_i),
        .pd_oe(wd_det_pd),
        .done_q(),
        .opt_q(wd_det_opt)
    );

    // Supervisor sequence: hold, identify pins, delay, run
    always_comb begin
        state_d = state_q;
        unique case (state_q)
            SV_HOLD: if (!supply_fault) state_d = SV_DETECT;
            SV_DETECT: if (rst_det_done) state_d = SV_DELAY;
            SV_DELAY: if (dly_cnt >= rst_dly) state_d = SV_RUN;
            SV_RUN: state_d = SV_RUN;
        endcase
        if (supply_fault) begin
            state_d = SV_HOLD; // Any fault reasserts reset and restarts detection
        end
    end

    always_ff @(posedge mclk) begin
        if (srst) begin
            state_q <= SV_HOLD;
        end else begin
            state_q <= state_d;
        end
    end

    // Options and selects latched when identification ends
    always_ff @(posedge mclk) begin
        if (srst) begin
            cfg_q <= '{rst_opt: OPT_NC, wd_opt: OPT_NC, sel: 2'h0};
        end else if (state_q == SV_DETECT && rst_det_done) begin
            cfg_q <= '{rst_opt: rst_det_opt, wd_opt: wd_det_opt,
                       sel: {window_ratio_sel_a, window_ratio_sel_b}};
        end
    end

    // Release delay in ticks for the latched option
    always_comb begin
        unique case (cfg_q.rst_opt)
            OPT_NC: rst_dly = RST_NC_US;
            OPT_PU: rst_dly = RST_PU_US;
            OPT_CAP: rst_dly = clamp_us(cap_rst_q, RST_CAP_MIN_US, RST_CAP_MAX_US);
            default: rst_dly = RST_NC_US;
        endcase
    end

    assign win = win_bounds(cfg_q.wd_opt, cfg_q.sel, cap_wd_q);
    assign wd_off = (cfg_q.sel == SEL_OFF);

    // Delay counter serves the release delay and the fault pulse
    svw_interval u_dly (
        .mclk(mclk),
        .srst(srst),
        .clr((state_q != SV_DELAY) && !fault_q),
        .tick(tick),
        .cnt_q(dly_cnt)
    );

    // Window counter restarts on each accepted kick and outside operation
    svw_interval u_win (
        .mclk(mclk),
        .srst(srst),
        .clr(!wd_active || kick_fall),
        .tick(tick),
        .cnt_q(win_cnt)
    );

    // Kick edge detection; ignored unless running
    always_ff @(posedge mclk) begin
        if (srst) begin
            kick_prev_q <= 1'b0;
        end else begin
            kick_prev_q <= watchdog_kick_input;
        end
    end
    assign kick_fall = kick_prev_q && !watchdog_kick_input;

    // Window check: early later kick or missing kick by the upper bound
    assign wd_active = (state_q == SV_RUN) && !wd_off && !fault_q;
    assign fault_start = wd_active &&
        ((kick_fall && !first_q && (win_cnt < win.lower)) ||
         (win_cnt >= win.upper));
    assign fault_end = fault_q && (dly_cnt >= rst_dly);

    // Fault pulse and first-kick tracking
    always_ff @(posedge mclk) begin
        if (srst || state_q != SV_RUN) begin
            fault_q <= 1'b0; // Released during reset
            first_q <= 1'b1;
        end else if (fault_start) begin
            fault_q <= 1'b1;
        end else if (fault_end) begin
            fault_q <= 1'b0;
            first_q <= 1'b1;
        end else if (wd_active && kick_fall) begin
            first_q <= 1'b0; // Later kicks must respect the lower bound
        end
    end

    // Pin drives: discharge in hold, detector pulldown, released while charging
    assign reset_delay_config_pin_oe = (state_q == SV_HOLD) || rst_det_pd;
    assign reset_delay_config_pin_o = 1'b0;
    assign watchdog_window_config_pin_oe = wd_det_pd;
    assign watchdog_window_config_pin_o = 1'b0;

    // Registered host outputs
    always_ff @(posedge mclk) begin
        if (srst) begin
            reset_out_n <= 1'b0;
            watchdog_fault_output_oe <= 1'b0;
        end else begin
            reset_out_n <= (state_d == SV_RUN);
            watchdog_fault_output_oe <= fault_q && (state_d == SV_RUN);
        end
    end
    assign watchdog_fault_output_o = 1'b0;

    // APB decode
    assign apb_setup = apb_req.psel && !apb_req.penable;
    assign apb_wr = apb_req.psel && apb_req.penable && apb_req.pwrite && addr_ok;
    assign addr_ok = (apb_req.paddr == REG_STATUS) || (apb_req.paddr == REG_MASK) ||
                     (apb_req.paddr == REG_CAP_RST) || (apb_req.paddr == REG_CAP_WD) ||
                     (apb_req.paddr == REG_INFO);

    // Sticky events; a new event wins over a clearing write
    assign events[EV_WD_FAULT] = fault_start;
    assign events[EV_RST_ASSERT] = (state_q != SV_HOLD) && supply_fault;
    assign events[EV_DET_DONE] = (state_q == SV_DETECT) && rst_det_done;

    always_ff @(posedge mclk) begin
        if (srst) begin
            status_q <= STATUS_RST;
        end else if (apb_wr && apb_req.paddr == REG_STATUS) begin
            status_q <= (status_q & ~apb_req.pwdata[EV_W-1:0]) | events;
        end else begin
            status_q <= status_q | events;
        end
    end

    // Writable registers
    always_ff @(posedge mclk) begin
        if (srst) begin
            mask_q <= MASK_RST;
            cap_rst_q <= CAP_RST_RST;
            cap_wd_q <= CAP_WD_RST;
        end else if (apb_wr) begin
            if (apb_req.paddr == REG_MASK) mask_q <= apb_req.pwdata[EV_W-1:0];
            if (apb_req.paddr == REG_CAP_RST) cap_rst_q <= apb_req.pwdata[CNT_W-1:0];
            if (apb_req.paddr == REG_CAP_WD) cap_wd_q <= apb_req.pwdata[CNT_W-1:0];
        end
    end

    // Read mux
    always_comb begin
        rdata = 32'h0000_0000;
        unique case (apb_req.paddr)
            REG_STATUS: rdata[EV_W-1:0] = status_q;
            REG_MASK: rdata[EV_W-1:0] = mask_q;
            REG_CAP_RST: rdata[CNT_W-1:0] = cap_rst_q;
            REG_CAP_WD: rdata[CNT_W-1:0] = cap_wd_q;
            REG_INFO: begin
                rdata[INFO_RST_OPT +: 2] = cfg_q.rst_opt;
                rdata[INFO_WD_OPT +: 2] = cfg_q.wd_opt;
                rdata[INFO_SEL +: 2] = cfg_q.sel;
                rdata[INFO_STATE +: 2] = state_q;
                rdata[INFO_RST_N] = reset_out_n;
                rdata[INFO_WDO] = watchdog_fault_output_oe;
                rdata[INFO_WD_OFF] = wd_off;
            end
            default: rdata = 32'h0000_0000;
        endcase
    end

    // Read data captured in the setup cycle
    always_ff @(posedge mclk) begin
        if (srst) begin
            prdata_q <= 32'h0000_0000;
        end else if (apb_setup) begin
            prdata_q <= rdata;
        end
    end

    // Zero-wait answer, error on unmapped address
    assign apb_rsp.pready = 1'b1;
    assign apb_rsp.pslverr = apb_req.psel && apb_req.penable && !addr_ok;
    assign apb_rsp.prdata = prdata_q;

    // Interrupt level
    assign irq = |(status_q & mask_q);

endmodule : svw_top

//--- verif/svw_assertions.sv
// Checker of the supervisor timing block, watching only its top-level ports.
// Assumes it is bound to every instance of svw_top and shares its tick parameter.
`timescale 1ns/10ps
module svw_assertions #(
    parameter int unsigned TICK_CYC = 200
) (
    // Clock and reset
    input wire logic mclk,
    input wire logic srst,
    // Supervisor side
    input wire logic supply_fault,
    input wire logic reset_delay_config_pin_o,
    input wire logic reset_delay_config_pin_oe,
    input wire logic reset_out_n,
    // Watchdog side
    input wire logic watchdog_fault_output_o,
    input wire logic watchdog_fault_output_oe
);
    import svw_pkg::*;
    default clocking cb @(posedge mclk); endclocking
    default disable iff (srst);
    logic [31:0] quiet_q;
    // Cycles since the supply last faulted, saturating
    always_ff @(posedge mclk) begin
        if (srst || supply_fault) quiet_q <= 32'h0;
        else if (quiet_q != 32'hFFFFFFFF) quiet_q <= quiet_q + 32'h1;
    end
    sequence s_quiet;
        !supply_fault [*8];
    endsequence
    property p_rst_fault; supply_fault |-> ##2 !reset_out_n; endproperty
    property p_discharge; supply_fault |=> reset_delay_config_pin_oe; endproperty
    property p_pulldown; reset_delay_config_pin_oe |-> !reset_delay_config_pin_o; endproperty
    property p_release; $rose(reset_out_n) |-> quiet_q >= 32'(1000 * TICK_CYC); endproperty
    property p_wdo_quiet; !reset_out_n [*2] |-> !watchdog_fault_output_oe; endproperty
    property p_wdo_level; watchdog_fault_output_oe |-> !watchdog_fault_output_o; endproperty
    property p_wdo_run; $rose(watchdog_fault_output_oe) |-> reset_out_n; endproperty
    property p_wdo_hold;
        ($rose(watchdog_fault_output_oe) ##0 s_quiet) |-> watchdog_fault_output_oe;
    endproperty
    a_rst_fault: assert property (p_rst_fault)
        else $error("reset output not asserted after supply fault");
    a_discharge: assert property (p_discharge)
        else $error("delay pin not discharged in reset");
    a_pulldown: assert property (p_pulldown)
        else $error("delay pin driven high");
    a_release: assert property (p_release)
        else $error("reset released too early");
    a_wdo_quiet: assert property (p_wdo_quiet)
        else $error("fault output active during reset");
    a_wdo_level: assert property (p_wdo_level)
        else $error("fault output driven high");
    a_wdo_run: assert property (p_wdo_run)
        else $error("fault started outside run");
    a_wdo_hold: assert property (p_wdo_hold)
        else $error("fault output released too soon");
endmodule : svw_assertions

bind svw_top svw_assertions #(.TICK_CYC(TICK_CYC)) u_chk (.mclk, .srst, .supply_fault,
    .reset_delay_config_pin_o, .reset_delay_config_pin_oe, .reset_out_n,
    .watchdog_fault_output_o, .watchdog_fault_output_oe);

//--- verif/svw_host.sv
// Host model: kicks the watchdog line with falling edges at a set spacing.
// Assumes the bench gives enable and spacing in clock cycles.
`timescale 1ns/10ps
module svw_host (
    // Clock
    input wire logic mclk,
    // Control from the bench
    input wire logic en,
    input wire logic [15:0] gap,
    // Kick line
    output logic kick
);
    logic [15:0] cnt_q = 16'h0;
    initial kick = 1'b1;
    // Line drops for four cycles at the start of each period
    always @(posedge mclk) begin
        cnt_q <= (!en || cnt_q >= gap) ? 16'h0 : cnt_q + 16'h1;
        kick <= !(en && cnt_q < 16'h4);
    end
endmodule : svw_host

//--- verif/tb_top.sv
// Self-checking bench of the supervisor timing block with one tick per cycle.
// Assumes the host model drives the kick line and the bench resolves the pins.
`timescale 1ns/10ps
module tb_top;
    import svw_pkg::*;
    logic mclk = 1'b0, srst = 1'b1, supply_fault = 1'b0, sel_a = 1'b1, sel_b = 1'b1;
    logic host_en = 1'b0, err;
    logic [15:0] gap = 16'h0BB8;
    logic [31:0] rd;
    logic [31:0] exp_rst [4] = '{32'h0, 32'h0, 32'h2BC, 32'hF514};
    svw_apb_req_t apb_req = '0;
    svw_apb_rsp_t apb_rsp;
    svw_opt_t rst_opt = OPT_CAP, wd_opt = OPT_PU;
    logic dly_oe, wd_oe, dly_o, wd_o, rst_n, wdo_o, wdo_oe, irq, kick;
    integer seed = 32'hC46B2C54;
    int bad_count = 0, n_compared = 0, cyc = 0, n_fault = 0, dly, t0;
    // Board side of the pins: pull-up, open or capacitor
    wire dly_pin = (rst_opt == OPT_PU) | (rst_opt == OPT_NC & !dly_oe);
    wire wd_pin = (wd_opt == OPT_PU) | (wd_opt == OPT_NC & !wd_oe);

    svw_top #(.TICK_CYC(1)) DUT (.mclk, .srst, .apb_req, .apb_rsp, .supply_fault,
        .reset_delay_config_pin_i(dly_pin), .reset_delay_config_pin_o(dly_o),
        .reset_delay_config_pin_oe(dly_oe), .watchdog_window_config_pin_i(wd_pin),
        .watchdog_window_config_pin_o(wd_o), .watchdog_window_config_pin_oe(wd_oe),
        .window_ratio_sel_a(sel_a), .window_ratio_sel_b(sel_b), .watchdog_kick_input(kick),
        .reset_out_n(rst_n), .watchdog_fault_output_o(wdo_o),
        .watchdog_fault_output_oe(wdo_oe), .irq);
    svw_host HOST (.mclk, .en(host_en), .gap, .kick);

    // Clock, fault time and hang guard
    always #2.5 mclk = ~mclk;
    always @(posedge mclk) begin
        cyc <= cyc + 1;
        if (wdo_oe === 1'b1) n_fault <= n_fault + 1;
        if (cyc == 80000) begin
            bad_count++;
            close_out();
        end
    end

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string what);
        n_compared++;
        if (seen !== exp) begin
            bad_count++;
            $display("mismatch at %0t: %s", $time, what);
        end
    endtask : chk

    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        apb_req <= '{1'b1, 1'b0, w, a, d};
        @(posedge mclk);
        apb_req.penable <= 1'b1;
        do @(posedge mclk); while (apb_rsp.pready !== 1'b1);
        rd = apb_rsp.prdata;
        err = apb_rsp.pslverr;
        apb_req <= '0;
        @(posedge mclk);
    endtask : apb

    function automatic logic near(int got, int want);
        return got + 3 >= want && got <= want + 8;
    endfunction : near

    function automatic logic [31:0] info(svw_opt_t r, svw_opt_t w, logic [1:0] s, logic off);
        return {21'h0, off, 1'b0, 1'b1, 2'b11, s, w, r};
    endfunction : info

    task automatic close_out();
        $display("compared %0d, mismatches %0d", n_compared, bad_count);
        if (bad_count == 0 && n_compared > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask : close_out

    initial begin
        repeat (3) @(posedge mclk);
        srst <= 1'b0;
        t0 = cyc;
        for (int i = 0; i < 4; i++) begin
            apb(1'b0, 8'(4 * i), 32'h0);
            chk(rd, exp_rst[i], "reset value");
        end
        apb(1'b0, 8'h14, 32'h0);
        chk({rd[30:0], err}, 32'h1, "unmapped read");
        dly = 700 + ($random(seed) & 32'hFF);
        apb(1'b1, REG_MASK, 32'h7);
        apb(1'b1, REG_CAP_RST, dly);
        wait (rst_n === 1'b1);
        chk(near(cyc - t0, 381 + dly), 1'b1, "release time");
        chk(irq, 1'b1, "irq on detect");
        apb(1'b0, REG_INFO, 32'h0);
        chk(rd & 32'h7FF, info(OPT_CAP, OPT_PU, 2'b11, 1'b0), "info");
        apb(1'b1, REG_STATUS, 32'h7);
        chk(irq, 1'b0, "irq clear");
        gap <= 16'(2000 + ($random(seed) & 32'hFFF));
        host_en <= 1'b1;
        repeat (12000) @(posedge mclk);
        chk(n_fault, 0, "fault in window");
        gap <= 16'h01F4;
        wait (wdo_oe === 1'b1);
        t0 = cyc;
        host_en <= 1'b0;
        wait (wdo_oe === 1'b0);
        chk(near(cyc - t0, dly), 1'b1, "fault hold");
        t0 = cyc;
        wait (wdo_oe === 1'b1);
        chk(near(cyc - t0, 11000), 1'b1, "upper bound");
        wd_opt <= OPT_NC;
        rst_opt <= OPT_PU;
        sel_b <= 1'b0;
        apb(1'b0, REG_INFO, 32'h0);
        chk(rd[5:4], 2'b11, "selects kept");
        supply_fault <= 1'b1;
        repeat (5) @(posedge mclk);
        chk({rst_n, wdo_oe}, 2'b00, "fault in reset");
        chk({dly_o, wd_o, wdo_o, dly_oe}, 4'h1, "pin drive");
        supply_fault <= 1'b0;
        t0 = cyc;
        wait (rst_n === 1'b1);
        chk(near(cyc - t0, 381 + 10000), 1'b1, "pull-up delay");
        apb(1'b0, REG_STATUS, 32'h0);
        chk(rd, 32'h7, "status");
        apb(1'b0, REG_INFO, 32'h0);
        chk(rd & 32'h7FF, info(OPT_PU, OPT_NC, 2'b10, 1'b1), "info");
        t0 = n_fault;
        repeat (12000) @(posedge mclk);
        chk(n_fault - t0, 0, "disabled fault");
        close_out();
    end
endmodule : tb_top
